// ==== design/pbs_pkg.sv ====
// Functional notes
// - power on after button low 32 ms
// - blank kill 512 ms, abort if low
// - blanking ignores kill, button, undervoltage
// - kill low releases enable when running
// - button held 32 ms raises interrupt request
// - interrupt min 32 ms, held while the owning input stays low
// - long hold releases enable and interrupt
// - power-down delay 64 ms plus extra
// - undervoltage 32 ms raises interrupt request
// - persistent undervoltage releases enable automatically
// - undervoltage locks out power on
// - one source owns power-down sequence
// - power-fail output follows its input
// - reset held 200 ms after supply
// - enable polarity selectable, same conditions
package pbs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEBOUNCE_MS = 32;
  localparam int BLANK_MS = 512;
  localparam int MIN_PULSE_MS = 32;
  localparam int PD_BASE_MS = 64;
  localparam int RESET_HOLD_MS = 200;
  localparam int TICK_W = 12;
  localparam logic [TICK_W-1:0] DEBOUNCE_TICKS = TICK_W'(DEBOUNCE_MS * 1000 / TICK_US);
  localparam logic [TICK_W-1:0] BLANK_TICKS = TICK_W'(BLANK_MS * 1000 / TICK_US);
  localparam logic [TICK_W-1:0] MIN_PULSE_TICKS = TICK_W'(MIN_PULSE_MS * 1000 / TICK_US);
  localparam logic [TICK_W-1:0] PD_BASE_TICKS = TICK_W'(PD_BASE_MS * 1000 / TICK_US);
  localparam logic [TICK_W-1:0] RESET_HOLD_TICKS = TICK_W'(RESET_HOLD_MS * 1000 / TICK_US);
  localparam logic [TICK_W-1:0] ZERO_TICKS = 12'h000;
  localparam logic [15:0] EXTRA_MS_DEFAULT = 16'h0000;
  typedef enum logic [2:0] {ST_OFF, ST_BLANK, ST_ON, ST_IRQ, ST_WAIT_REL} pbs_state_type;
  typedef enum logic [1:0] {OWN_NONE, OWN_BUTTON, OWN_UV} pbs_owner_type;
endpackage

// ==== design/pbs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// three-stage input synchroniser, change accepted when stages two and three agree
module pbs_sync
  import pbs_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic dout_q;
  // sampling chain
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      dout_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout_q <= s3_q;
    end
  end
  assign dout = dout_q;
endmodule
`default_nettype wire

// ==== design/pbs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// push-button power sequencer top
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter logic EN_ACTIVE_HIGH = 1'b1,
  parameter logic [15:0] EXTRA_PD_MS = EXTRA_MS_DEFAULT
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic button_n,
  input wire logic kill_n,
  input wire logic undervolt_in,
  input wire logic powerfail_in,
  input wire logic supply_monitor_in,
  output logic enable_out,
  output logic irq_n,
  output logic powerfail_out_n,
  output logic reset_out_n
);
  import pbs_pkg::*;

  localparam int PD_TOTAL = int'(PD_BASE_TICKS) + int'(EXTRA_PD_MS) * 1000 / TICK_US;
  localparam int PD_W = 20;
  localparam logic [PD_W-1:0] PD_TICKS = PD_W'(PD_TOTAL);

  logic btn_s;
  logic kill_s;
  logic uv_s;
  logic pf_s;
  logic vm_s;

  pbs_sync #(.RESET_VAL(1'b1)) u_btn (.mclk(mclk), .nrst(nrst), .din(button_n), .dout(btn_s));
  pbs_sync #(.RESET_VAL(1'b1)) u_kill (.mclk(mclk), .nrst(nrst), .din(kill_n), .dout(kill_s));
  pbs_sync #(.RESET_VAL(1'b1)) u_uv (.mclk(mclk), .nrst(nrst), .din(undervolt_in),
    .dout(uv_s));
  pbs_sync #(.RESET_VAL(1'b1)) u_pf (.mclk(mclk), .nrst(nrst), .din(powerfail_in),
    .dout(pf_s));
  pbs_sync #(.RESET_VAL(1'b0)) u_vm (.mclk(mclk), .nrst(nrst), .din(supply_monitor_in),
    .dout(vm_s));

  // shared tick prescaler for every interval
  logic [15:0] pre_q;
  logic tick;
  assign tick = (pre_q == 16'(TICK_DIV - 1));
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pre_q <= 16'h0000;
    else
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
  end

  // state and interval counters
  pbs_state_type st_q;
  pbs_state_type st_d;
  pbs_owner_type own_q;
  pbs_owner_type own_d;
  logic [PD_W-1:0] low_q;
  logic [PD_W-1:0] low_d;
  logic [TICK_W-1:0] tmr_q;
  logic [TICK_W-1:0] tmr_d;
  logic en_q;
  logic en_d;
  logic irq_q;
  logic irq_d;

  // owner input level and releases
  logic own_low;
  logic btn_low;
  logic uv_low;
  assign btn_low = !btn_s;
  assign uv_low = !uv_s;
  assign own_low = (own_q == OWN_BUTTON) ? btn_low : uv_low;
  logic forced;
  assign forced = own_low && (low_q >= PD_TICKS);
  logic pulse_done;
  assign pulse_done = (tmr_q >= MIN_PULSE_TICKS);

  // sequencing decisions
  always_comb
  begin
    st_d = st_q;
    own_d = own_q;
    low_d = low_q;
    tmr_d = tmr_q;
    en_d = en_q;
    irq_d = irq_q;
    unique case (st_q)
      ST_OFF:
      begin
        en_d = 1'b0;
        irq_d = 1'b0;
        own_d = OWN_NONE;
        if (btn_low && !uv_low)
        begin
          if (tick)
            tmr_d = tmr_q + 12'h001;
          if (tick && tmr_q + 12'h001 >= DEBOUNCE_TICKS)
          begin
            st_d = ST_BLANK;
            en_d = 1'b1;
            tmr_d = ZERO_TICKS;
          end
        end
        else
          tmr_d = ZERO_TICKS;
      end
      ST_BLANK:
      begin
        // inputs ignored until blanking expires
        if (tick)
          tmr_d = tmr_q + 12'h001;
        if (tick && tmr_q + 12'h001 >= BLANK_TICKS)
        begin
          tmr_d = ZERO_TICKS;
          if (!kill_s)
          begin
            st_d = ST_WAIT_REL;
            en_d = 1'b0;
          end
          else
            st_d = ST_ON;
        end
      end
      ST_ON:
      begin
        if (!kill_s)
        begin
          st_d = ST_WAIT_REL;
          en_d = 1'b0;
        end
        else if (own_q == OWN_NONE)
        begin
          low_d = '0;
          if (btn_low)
            own_d = OWN_BUTTON;
          else if (uv_low)
            own_d = OWN_UV;
        end
        else if (!own_low)
        begin
          own_d = OWN_NONE;
          low_d = '0;
        end
        else if (tick)
        begin
          low_d = low_q + 20'h00001;
          if (low_q + 20'h00001 >= PD_W'(DEBOUNCE_TICKS))
          begin
            st_d = ST_IRQ;
            irq_d = 1'b1;
            tmr_d = ZERO_TICKS;
          end
        end
      end
      ST_IRQ:
      begin
        // hold time counts only while the owner stays low
        if (!own_low)
          low_d = '0;
        else if (tick)
          low_d = low_q + 20'h00001;
        if (tick && !pulse_done)
          tmr_d = tmr_q + 12'h001;
        if (!kill_s)
        begin
          st_d = ST_WAIT_REL;
          en_d = 1'b0;
          irq_d = 1'b0;
        end
        else if (forced)
        begin
          st_d = ST_WAIT_REL;
          en_d = 1'b0;
          irq_d = 1'b0;
        end
        else if (pulse_done && !own_low)
        begin
          st_d = ST_ON;
          irq_d = 1'b0;
          own_d = OWN_NONE;
          low_d = '0;
        end
      end
      ST_WAIT_REL:
      begin
        // a held button must not re-arm power on
        en_d = 1'b0;
        irq_d = 1'b0;
        tmr_d = ZERO_TICKS;
        if (btn_s)
          st_d = ST_OFF;
      end
      default:
      begin
        st_d = ST_OFF;
        en_d = 1'b0;
        irq_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_OFF;
      own_q <= OWN_NONE;
      low_q <= '0;
      tmr_q <= ZERO_TICKS;
      en_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      own_q <= own_d;
      low_q <= low_d;
      tmr_q <= tmr_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // supply supervisor reset hold
  logic [TICK_W-1:0] rst_cnt_q;
  logic rst_n_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_cnt_q <= ZERO_TICKS;
      rst_n_q <= 1'b0;
    end
    else if (!vm_s)
    begin
      rst_cnt_q <= ZERO_TICKS;
      rst_n_q <= 1'b0;
    end
    else if (!rst_n_q && tick)
    begin
      rst_cnt_q <= rst_cnt_q + 12'h001;
      if (rst_cnt_q + 12'h001 >= RESET_HOLD_TICKS)
        rst_n_q <= 1'b1;
    end
  end

  // registered outputs
  logic enable_q;
  logic irq_n_q;
  logic pfo_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_q <= !EN_ACTIVE_HIGH;
      irq_n_q <= 1'b1;
      pfo_q <= 1'b1;
    end
    else
    begin
      enable_q <= EN_ACTIVE_HIGH ? en_d : !en_d;
      irq_n_q <= !irq_d;
      pfo_q <= pf_s;
    end
  end
  assign enable_out = enable_q;
  assign irq_n = irq_n_q;
  assign powerfail_out_n = pfo_q;
  assign reset_out_n = rst_n_q;
endmodule
`default_nettype wire

// ==== tb/pbs_sequencer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// port checker for the sequencer
module pbs_sequencer_sva
  import pbs_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter logic EN_ACTIVE_HIGH = 1'b1,
  parameter logic [15:0] EXTRA_PD_MS = EXTRA_MS_DEFAULT
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic button_n,
  input wire logic kill_n,
  input wire logic undervolt_in,
  input wire logic powerfail_in,
  input wire logic supply_monitor_in,
  input wire logic enable_out,
  input wire logic irq_n,
  input wire logic powerfail_out_n,
  input wire logic reset_out_n
);
  localparam int T = TICK_DIV;
  localparam int PD = PD_BASE_MS + int'(EXTRA_PD_MS);
  logic [31:0] btn_c, irq_c, sup_c;
  wire logic en_on = enable_out == EN_ACTIVE_HIGH;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // cycles of button low, request low, supply high
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      btn_c <= 32'h0;
      irq_c <= 32'h0;
      sup_c <= 32'h0;
    end
    else
    begin
      btn_c <= button_n ? 32'h0 : btn_c + 32'h1;
      irq_c <= irq_n ? 32'h0 : irq_c + 32'h1;
      sup_c <= supply_monitor_in ? sup_c + 32'h1 : 32'h0;
    end
  // input held low for a few cycles
  sequence s_pfi_low;
    !powerfail_in [*6];
  endsequence
  sequence s_sup_low;
    !supply_monitor_in [*6];
  endsequence
  sequence s_uv_low;
    !undervolt_in [*6];
  endsequence
  a_pfo_tracks_low: assert property (s_pfi_low |-> !powerfail_out_n)
    else $error("powerfail output not low");
  a_rst_on_low: assert property (s_sup_low |-> !reset_out_n)
    else $error("reset not low");
  a_rst_hold_min: assert property ($rose(reset_out_n) |-> sup_c >= 199 * T)
    else $error("reset released early");
  a_rst_hold_max: assert property (sup_c > 202 * T + 8 |-> reset_out_n)
    else $error("reset held too long");
  a_en_needs_press: assert property ($rose(en_on) |-> btn_c >= 31 * T)
    else $error("enable without debounced press");
  a_irq_when_on: assert property ($fell(irq_n) |-> en_on)
    else $error("request while off");
  a_irq_min_width: assert property ($rose(irq_n) && en_on |-> irq_c >= 31 * T)
    else $error("request pulse too short");
  a_forced_off: assert property (btn_c > (PD + 2) * T + 8 |-> !en_on && irq_n)
    else $error("long hold did not release");
  a_uv_lockout: assert property (s_uv_low ##0 !en_on |=> !en_on)
    else $error("enable while undervoltage low");
endmodule
bind pbs_sequencer pbs_sequencer_sva #(.TICK_DIV(TICK_DIV), .EN_ACTIVE_HIGH(EN_ACTIVE_HIGH),
  .EXTRA_PD_MS(EXTRA_PD_MS)) pbs_sequencer_sva_inst (.mclk(mclk), .nrst(nrst),
  .button_n(button_n), .kill_n(kill_n), .undervolt_in(undervolt_in),
  .powerfail_in(powerfail_in), .supply_monitor_in(supply_monitor_in),
  .enable_out(enable_out), .irq_n(irq_n), .powerfail_out_n(powerfail_out_n),
  .reset_out_n(reset_out_n));
`default_nettype wire

// ==== tb/pbs_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// processor side: boots, then answers requests with kill
module pbs_cpu_model
#(
  parameter int BOOT = 1000,
  parameter int WORK = 60
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic power_on,
  input wire logic irq_n,
  input wire logic boot_ok,
  input wire logic answer_irq,
  output logic kill_n
);
  int cnt;
  // unpowered holds kill low, boot raises it, housekeeping drops it
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst || !power_on)
    begin
      cnt <= 0;
      kill_n <= 1'b0;
    end
    else if (!kill_n)
    begin
      cnt <= cnt + 1;
      kill_n <= boot_ok && cnt == BOOT;
    end
    else
    begin
      cnt <= irq_n ? 0 : cnt + 1;
      kill_n <= !(answer_irq && cnt == WORK);
    end
endmodule
`default_nettype wire

// ==== tb/pbs_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench, low-active enable
module pbs_sequencer_tb_top;
  import pbs_pkg::*;
  localparam int T = 10;
  localparam logic EH = 1'b0;
  logic mclk, nrst, button_n, undervolt_in, powerfail_in, supply_monitor_in;
  logic boot_ok, answer_irq;
  wire logic kill_n, enable_out, irq_n, powerfail_out_n, reset_out_n, enable_hi;
  wire logic en_on = enable_out === EH;
  int bad_count, checked, n;
  pbs_sequencer #(.TICK_DIV(T), .EN_ACTIVE_HIGH(EH), .EXTRA_PD_MS(16'h0002))
    pbs_sequencer_inst (.mclk(mclk), .nrst(nrst), .button_n(button_n), .kill_n(kill_n),
    .undervolt_in(undervolt_in), .powerfail_in(powerfail_in),
    .supply_monitor_in(supply_monitor_in), .enable_out(enable_out), .irq_n(irq_n),
    .powerfail_out_n(powerfail_out_n), .reset_out_n(reset_out_n));
  pbs_cpu_model pbs_cpu_model_inst (.mclk(mclk), .nrst(nrst), .power_on(en_on),
    .irq_n(irq_n), .boot_ok(boot_ok), .answer_irq(answer_irq), .kill_n(kill_n));
  // same stimulus, high-active enable polarity
  pbs_sequencer #(.TICK_DIV(T), .EN_ACTIVE_HIGH(1'b1), .EXTRA_PD_MS(16'h0002))
    pbs_sequencer_hi_inst (.mclk(mclk), .nrst(nrst), .button_n(button_n), .kill_n(kill_n),
    .undervolt_in(undervolt_in), .powerfail_in(powerfail_in),
    .supply_monitor_in(supply_monitor_in), .enable_out(enable_hi), .irq_n(),
    .powerfail_out_n(), .reset_out_n());
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // wait ticks, then step off the edge
  task automatic w(int t);
    repeat (t * T) @(posedge mclk);
    #1;
  endtask
  task automatic ck(string nm, logic seen, logic exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic pr(int t);
    button_n = 1'b0;
    w(t);
  endtask
  task automatic pon;
    pr(34);
    button_n = 1'b1;
    w(520);
  endtask
  function automatic logic forced(int t);
    return t > PD_BASE_MS + 2;
  endfunction
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    end_sim();
  end
  // tests
  initial
  begin
    button_n = 1'b1;
    undervolt_in = 1'b1;
    powerfail_in = 1'b1;
    supply_monitor_in = 1'b1;
    boot_ok = 1'b1;
    answer_irq = 1'b0;
    nrst = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    #1;
    nrst = 1'b1;
    void'($urandom(32'h695fb53d));
    w(190);
    ck("rst", reset_out_n, 1'b0);
    ck("en_hi", enable_hi, 1'b0);
    w(15);
    ck("rst", reset_out_n, 1'b1);
    repeat (6)
    begin
      powerfail_in = 1'($urandom);
      w(1);
      ck("pfo", powerfail_out_n, powerfail_in);
    end
    supply_monitor_in = 1'b0;
    w(1);
    ck("rst", reset_out_n, 1'b0);
    supply_monitor_in = 1'b1;
    $display("test supervisor done");
    pr(20);
    button_n = 1'b1;
    w(5);
    ck("en", en_on, 1'b0);
    pr(34);
    ck("en", en_on, 1'b1);
    ck("en_hi", enable_hi, 1'b1);
    button_n = 1'b1;
    w(5);
    pr(40);
    ck("irq", irq_n, 1'b1);
    button_n = 1'b1;
    w(520);
    ck("en", en_on, 1'b1);
    $display("test power on done");
    pr(34);
    button_n = 1'b1;
    w(2);
    ck("irq", irq_n, 1'b0);
    w(40);
    ck("irq", irq_n, 1'b1);
    ck("en", en_on, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      n = (k == 0) ? 70 : 34 + int'($urandom % 27) + 36 * int'($urandom % 2);
      pr(n);
      ck("irq", irq_n, forced(n));
      ck("en", en_on, !forced(n));
      button_n = 1'b1;
      w(40);
      if (forced(n))
        pon();
    end
    $display("test interrupt done");
    answer_irq = 1'b1;
    pr(34);
    button_n = 1'b1;
    w(20);
    ck("en", en_on, 1'b0);
    ck("en_hi", enable_hi, 1'b0);
    answer_irq = 1'b0;
    undervolt_in = 1'b0;
    w(5);
    pr(40);
    ck("en", en_on, 1'b0);
    button_n = 1'b1;
    undervolt_in = 1'b1;
    w(5);
    pon();
    undervolt_in = 1'b0;
    w(40);
    ck("irq", irq_n, 1'b0);
    pr(10);
    button_n = 1'b1;
    w(25);
    ck("en", en_on, 1'b0);
    ck("irq", irq_n, 1'b1);
    undervolt_in = 1'b1;
    $display("test kill and undervoltage done");
    boot_ok = 1'b0;
    pon();
    ck("en", en_on, 1'b0);
    $display("test abort done");
    end_sim();
  end
endmodule
`default_nettype wire
